// File: gdcr_pkg.sv
// Package of register offsets, reset values, field layout and current tables for the gate current registers.
package gdcr_pkg;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam int          ADDR_W             = 8;
  localparam int          DATA_W             = 8;
  localparam int          CODE_W             = 4;
  localparam int          STEP_W             = 16;
  localparam logic [7:0]  HB3_GATE_CURRENT   = 8'h11;
  localparam logic [7:0]  HB4_GATE_CURRENT   = 8'h12;
  localparam logic [7:0]  LOW_CURRENT_CTRL   = 8'h17;
  localparam logic [7:0]  GATE_CURRENT_RESET = 8'hFF;
  localparam logic [7:0]  READ_ZERO          = 8'h00;
  localparam int          SOURCE_HI          = 7;
  localparam int          SOURCE_LO          = 4;
  localparam int          SINK_HI            = 3;
  localparam int          SINK_LO            = 0;
  localparam int          HB3_LOW_BIT        = 5;
  localparam int          HB4_LOW_BIT        = 4;
  localparam logic        LOW_RESET          = 1'b0;

  // ************************************************************
  // Drive tables in microamps
  // ************************************************************
  typedef logic [STEP_W-1:0] gdcr_step_t;

  localparam gdcr_step_t STD_TABLE [16] = '{
    16'h01F4, 16'h03E8, 16'h07D0, 16'h0BB8, 16'h0FA0, 16'h1388, 16'h1770, 16'h1B58,
    16'h1F40, 16'h2EE0, 16'h3E80, 16'h4E20, 16'h5DC0, 16'h7918, 16'hBB80, 16'hF230};
  localparam gdcr_step_t LOW_TABLE [16] = '{
    16'h0032, 16'h006E, 16'h00AA, 16'h00E6, 16'h0122, 16'h015E, 16'h019A, 16'h0258,
    16'h02D5, 16'h0352, 16'h03E8, 16'h04B0, 16'h0578, 16'h0640, 16'h0708, 16'h08FC};

endpackage

// File: gdcr_decode.sv
// Decoder from a current code and low-current enable to a drive step in microamps.
`timescale 1ns/10ps
module gdcr_decode (
  input  wire logic                        clk,
  input  wire logic                        reset,
  input  wire logic [gdcr_pkg::CODE_W-1:0] code,
  input  wire logic                        low_current,
  output      gdcr_pkg::gdcr_step_t        step
);

  // Registered so that the analog steering sees a clean glitch-free value.
  wire gdcr_pkg::gdcr_step_t next_step = low_current ? gdcr_pkg::LOW_TABLE[code]
                                                     : gdcr_pkg::STD_TABLE[code];

  always_ff @(posedge clk) begin
    if (reset) begin
      step <= gdcr_pkg::STD_TABLE[gdcr_pkg::GATE_CURRENT_RESET[gdcr_pkg::SINK_HI:gdcr_pkg::SINK_LO]];
    end else begin
      step <= next_step;
    end
  end

endmodule

// File: gdcr_regs.sv
// Gate drive current configuration registers for half-bridges 3 and 4.
// ************************************************************
// How it works
// - Register 0x11 holds half-bridge 3 currents, resets to all ones.
// - Register 0x12 holds half-bridge 4 currents, resets to all ones.
// - Bridge 3 bits 7..4 are the writable source code, reset ones.
// - Bridge 3 bits 3..0 are the writable sink code, reset ones.
// - Bridge 4 bits 7..4 are the writable source code, reset ones.
// - Bridge 4 bits 3..0 are the writable sink code, reset ones.
// - Higher code gives stronger drive, 0.5 mA up to 62 mA, or 0.05 mA up to 2.3 mA with low current enabled.
// - Per-bridge low-current enables are writable, reset to zero.
// ************************************************************
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/10ps
module gdcr_regs (
  input  wire logic                        clk,
  input  wire logic                        reset,
  input  wire logic [gdcr_pkg::ADDR_W-1:0] address,
  input  wire logic [gdcr_pkg::DATA_W-1:0] write_data,
  input  wire logic                        write_strobe,
  input  wire logic                        read_strobe,
  output      logic [gdcr_pkg::DATA_W-1:0] read_data,
  output      logic [gdcr_pkg::CODE_W-1:0] hb3_source_current_code,
  output      logic [gdcr_pkg::CODE_W-1:0] hb3_sink_current_code,
  output      logic [gdcr_pkg::CODE_W-1:0] hb4_source_current_code,
  output      logic [gdcr_pkg::CODE_W-1:0] hb4_sink_current_code,
  output      logic                        hb3_low_current_enable,
  output      logic                        hb4_low_current_enable,
  output      gdcr_pkg::gdcr_step_t        hb3_source_step,
  output      gdcr_pkg::gdcr_step_t        hb3_sink_step,
  output      gdcr_pkg::gdcr_step_t        hb4_source_step,
  output      gdcr_pkg::gdcr_step_t        hb4_sink_step
);

  // ************************************************************
  // Helper functions
  // ************************************************************
  function automatic logic address_hit(
    input logic [gdcr_pkg::ADDR_W-1:0] bus_address,
    input logic [gdcr_pkg::ADDR_W-1:0] register_offset
  );
    return bus_address == register_offset;
  endfunction

  function automatic logic [gdcr_pkg::CODE_W-1:0] source_field(
    input logic [gdcr_pkg::DATA_W-1:0] word
  );
    return word[gdcr_pkg::SOURCE_HI:gdcr_pkg::SOURCE_LO];
  endfunction

  function automatic logic [gdcr_pkg::CODE_W-1:0] sink_field(
    input logic [gdcr_pkg::DATA_W-1:0] word
  );
    return word[gdcr_pkg::SINK_HI:gdcr_pkg::SINK_LO];
  endfunction

  function automatic logic [gdcr_pkg::DATA_W-1:0] load_word(
    input logic                        load,
    input logic [gdcr_pkg::DATA_W-1:0] new_word,
    input logic [gdcr_pkg::DATA_W-1:0] old_word
  );
    return load ? new_word : old_word;
  endfunction

  function automatic logic load_bit(
    input logic load,
    input logic new_bit,
    input logic old_bit
  );
    return load ? new_bit : old_bit;
  endfunction

  // Other enable bits of the shared control word belong to bridges outside this block and read zero.
  function automatic logic [gdcr_pkg::DATA_W-1:0] pack_low_word(
    input logic low3,
    input logic low4
  );
    logic [gdcr_pkg::DATA_W-1:0] packed_word;
    packed_word                        = gdcr_pkg::READ_ZERO;
    packed_word[gdcr_pkg::HB3_LOW_BIT] = low3;
    packed_word[gdcr_pkg::HB4_LOW_BIT] = low4;
    return packed_word;
  endfunction

  function automatic logic [gdcr_pkg::DATA_W-1:0] select_word(
    input logic [gdcr_pkg::ADDR_W-1:0] bus_address,
    input logic [gdcr_pkg::DATA_W-1:0] word3,
    input logic [gdcr_pkg::DATA_W-1:0] word4,
    input logic [gdcr_pkg::DATA_W-1:0] word_low
  );
    logic [gdcr_pkg::DATA_W-1:0] result;
    case (bus_address)
      gdcr_pkg::HB3_GATE_CURRENT: begin
        result = word3;
      end
      gdcr_pkg::HB4_GATE_CURRENT: begin
        result = word4;
      end
      gdcr_pkg::LOW_CURRENT_CTRL: begin
        result = word_low;
      end
      default: begin
        result = gdcr_pkg::READ_ZERO;
      end
    endcase
    return result;
  endfunction

  // ************************************************************
  // Address decode
  // ************************************************************
  wire logic hit3   = address_hit(address, gdcr_pkg::HB3_GATE_CURRENT);
  wire logic hit4   = address_hit(address, gdcr_pkg::HB4_GATE_CURRENT);
  wire logic hitlow = address_hit(address, gdcr_pkg::LOW_CURRENT_CTRL);
  wire logic wr3    = write_strobe && hit3;
  wire logic wr4    = write_strobe && hit4;
  wire logic wrlow  = write_strobe && hitlow;

  // ************************************************************
  // Bridge 3 register
  // ************************************************************
  logic [gdcr_pkg::DATA_W-1:0] halfbridge3_gate_current;

  wire logic [gdcr_pkg::DATA_W-1:0] next_halfbridge3_gate_current =
    load_word(wr3, write_data, halfbridge3_gate_current);

  always_ff @(posedge clk) begin
    if (reset) begin
      halfbridge3_gate_current <= gdcr_pkg::GATE_CURRENT_RESET;
    end else begin
      halfbridge3_gate_current <= next_halfbridge3_gate_current;
    end
  end

  // ************************************************************
  // Bridge 4 register
  // ************************************************************
  logic [gdcr_pkg::DATA_W-1:0] halfbridge4_gate_current;

  wire logic [gdcr_pkg::DATA_W-1:0] next_halfbridge4_gate_current =
    load_word(wr4, write_data, halfbridge4_gate_current);

  always_ff @(posedge clk) begin
    if (reset) begin
      halfbridge4_gate_current <= gdcr_pkg::GATE_CURRENT_RESET;
    end else begin
      halfbridge4_gate_current <= next_halfbridge4_gate_current;
    end
  end

  // ************************************************************
  // Low-current enables
  // ************************************************************
  wire logic next_hb3_low_current_enable =
    load_bit(wrlow, write_data[gdcr_pkg::HB3_LOW_BIT], hb3_low_current_enable);
  wire logic next_hb4_low_current_enable =
    load_bit(wrlow, write_data[gdcr_pkg::HB4_LOW_BIT], hb4_low_current_enable);

  always_ff @(posedge clk) begin
    if (reset) begin
      hb3_low_current_enable <= gdcr_pkg::LOW_RESET;
    end else begin
      hb3_low_current_enable <= next_hb3_low_current_enable;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      hb4_low_current_enable <= gdcr_pkg::LOW_RESET;
    end else begin
      hb4_low_current_enable <= next_hb4_low_current_enable;
    end
  end

  // ************************************************************
  // Field views
  // ************************************************************
  assign hb3_source_current_code = source_field(halfbridge3_gate_current);
  assign hb3_sink_current_code   = sink_field(halfbridge3_gate_current);
  assign hb4_source_current_code = source_field(halfbridge4_gate_current);
  assign hb4_sink_current_code   = sink_field(halfbridge4_gate_current);

  // ************************************************************
  // Read port
  // ************************************************************
  // A read only copies a stored word, so it can never disturb the drive settings.
  wire logic [gdcr_pkg::DATA_W-1:0] low_word =
    pack_low_word(hb3_low_current_enable, hb4_low_current_enable);
  wire logic [gdcr_pkg::DATA_W-1:0] selected_word =
    select_word(address, halfbridge3_gate_current, halfbridge4_gate_current, low_word);
  wire logic [gdcr_pkg::DATA_W-1:0] next_read_data =
    read_strobe ? selected_word : gdcr_pkg::READ_ZERO;

  always_ff @(posedge clk) begin
    if (reset) begin
      read_data <= gdcr_pkg::READ_ZERO;
    end else begin
      read_data <= next_read_data;
    end
  end

  // ************************************************************
  // Current decode
  // ************************************************************
  gdcr_decode u_hb3_source (
    .clk         (clk),
    .reset       (reset),
    .code        (hb3_source_current_code),
    .low_current (hb3_low_current_enable),
    .step        (hb3_source_step)
  );
  gdcr_decode u_hb3_sink (
    .clk         (clk),
    .reset       (reset),
    .code        (hb3_sink_current_code),
    .low_current (hb3_low_current_enable),
    .step        (hb3_sink_step)
  );
  gdcr_decode u_hb4_source (
    .clk         (clk),
    .reset       (reset),
    .code        (hb4_source_current_code),
    .low_current (hb4_low_current_enable),
    .step        (hb4_source_step)
  );
  gdcr_decode u_hb4_sink (
    .clk         (clk),
    .reset       (reset),
    .code        (hb4_sink_current_code),
    .low_current (hb4_low_current_enable),
    .step        (hb4_sink_step)
  );

endmodule

// File: gdcr_regs_props.sv
// Checker of the gate current register ports.
`timescale 1ns/10ps
module gdcr_regs_props (
  input logic        clk,
  input logic        reset,
  input logic [7:0]  address,
  input logic [7:0]  write_data,
  input logic        write_strobe,
  input logic        read_strobe,
  input logic [7:0]  read_data,
  input logic [3:0]  hb3_source_current_code,
  input logic [3:0]  hb3_sink_current_code,
  input logic [3:0]  hb4_source_current_code,
  input logic [3:0]  hb4_sink_current_code,
  input logic        hb3_low_current_enable,
  input logic        hb4_low_current_enable,
  input logic [15:0] hb3_source_step,
  input logic [15:0] hb4_sink_step
);
  // ****************
  // Checks
  // ****************
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  wire [7:0]  c3  = {hb3_source_current_code, hb3_sink_current_code};
  wire [7:0]  c4  = {hb4_source_current_code, hb4_sink_current_code};
  wire [1:0]  wlo = write_data[5:4];
  wire        w3  = write_strobe && address == 8'h11;
  wire [15:0] e3  = hb3_low_current_enable ? gdcr_pkg::LOW_TABLE[hb3_source_current_code]
                                           : gdcr_pkg::STD_TABLE[hb3_source_current_code];
  wire [15:0] e4  = hb4_low_current_enable ? gdcr_pkg::LOW_TABLE[hb4_sink_current_code]
                                           : gdcr_pkg::STD_TABLE[hb4_sink_current_code];
  sequence s_rd3; read_strobe && address == 8'h11; endsequence
  property p_rst; disable iff (1'b0) reset |=> c3 == 8'hFF && c4 == 8'hFF && !hb4_low_current_enable
    && !hb3_low_current_enable; endproperty
  property p_wr3; w3 |=> c3 == $past(write_data); endproperty
  property p_wr4; write_strobe && address == 8'h12 |=> c4 == $past(write_data); endproperty
  property p_hold3; !w3 |=> $stable(c3); endproperty
  property p_rd3; s_rd3 |=> read_data == $past(c3); endproperty
  property p_idle; !read_strobe |=> read_data == 8'h00; endproperty
  property p_low; write_strobe && address == 8'h17 |=> {hb3_low_current_enable, hb4_low_current_enable} == $past(wlo);
  endproperty
  property p_step3; 1'b1 |=> hb3_source_step == $past(e3); endproperty
  property p_step4; 1'b1 |=> hb4_sink_step == $past(e4); endproperty
  a_rst: assert property (p_rst) else $error("reset value wrong");
  a_wr3: assert property (p_wr3) else $error("bridge 3 write lost");
  a_wr4: assert property (p_wr4) else $error("bridge 4 write lost");
  a_hold3: assert property (p_hold3) else $error("bridge 3 codes moved");
  a_rd3: assert property (p_rd3) else $error("bridge 3 read wrong");
  a_idle: assert property (p_idle) else $error("read data not idle");
  a_low: assert property (p_low) else $error("low enable write lost");
  a_step3: assert property (p_step3) else $error("bridge 3 step wrong");
  a_step4: assert property (p_step4) else $error("bridge 4 step wrong");
endmodule

// File: tb.sv
// Self-checking bench of the gate current registers.
`timescale 1ns/10ps
module tb;
  logic        clk = 0, reset = 1, write_strobe = 0, read_strobe = 0, l3, l4;
  logic [7:0]  address = 8'h00, write_data = 8'h00, read_data;
  logic [3:0]  s3, k3, s4, k4;
  logic [15:0] p3, n3, p4, n4;
  int          failures = 0, n_compared = 0, cycles = 0;
  always #2 clk = ~clk;
  gdcr_regs gdcr_regs_i (.clk(clk), .reset(reset), .address(address), .write_data(write_data),
    .write_strobe(write_strobe), .read_strobe(read_strobe), .read_data(read_data),
    .hb3_source_current_code(s3), .hb3_sink_current_code(k3), .hb4_source_current_code(s4),
    .hb4_sink_current_code(k4), .hb3_low_current_enable(l3), .hb4_low_current_enable(l4),
    .hb3_source_step(p3), .hb3_sink_step(n3), .hb4_source_step(p4), .hb4_sink_step(n4));
  // ****************
  // Tasks
  // ****************
  task automatic chk(string n, logic [15:0] e, logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge clk);
    address <= a;
    write_data <= d;
    write_strobe <= 1'b1;
    @(posedge clk);
    write_strobe <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] e);
    @(posedge clk);
    address <= a;
    read_strobe <= 1'b1;
    @(posedge clk);
    read_strobe <= 1'b0;
    #1 chk("read_data", {8'h00, e}, {8'h00, read_data});
  endtask
  task automatic t_reset();
    rd(8'h11, 8'hFF);
    rd(8'h12, 8'hFF);
    rd(8'h17, 8'h00);
    chk("hb4_sink_step", 16'hF230, n4);
  endtask
  task automatic t_fields();
    wr(8'h11, 8'h3A);
    wr(8'h12, 8'h5C);
    wr(8'h13, 8'h00);
    #1 chk("hb3_codes", 16'h003A, {8'h00, s3, k3});
    chk("hb4_codes", 16'h005C, {8'h00, s4, k4});
    rd(8'h11, 8'h3A);
    rd(8'h11, 8'h3A);
    rd(8'h12, 8'h5C);
    rd(8'h13, 8'h00);
  endtask
  task automatic t_steps();
    wr(8'h17, 8'h20);
    rd(8'h17, 8'h20);
    chk("hb3_low_current_enable", 16'h0001, {15'h0000, l3});
    chk("hb4_low_current_enable", 16'h0000, {15'h0000, l4});
    for (int i = 0; i < 16; i++) begin
      wr(8'h11, {i[3:0], i[3:0]});
      wr(8'h12, {i[3:0], i[3:0]});
      @(posedge clk);
      #1 chk("hb3_source_step", gdcr_pkg::LOW_TABLE[i], p3);
      chk("hb3_sink_step", gdcr_pkg::LOW_TABLE[i], n3);
      chk("hb4_source_step", gdcr_pkg::STD_TABLE[i], p4);
    end
    wr(8'h17, 8'h10);
    @(posedge clk);
    #1 chk("hb4_sink_step", 16'h08FC, n4);
    chk("hb3_source_step", 16'hF230, p3);
    chk("hb3_low_current_enable", 16'h0000, {15'h0000, l3});
    chk("hb4_low_current_enable", 16'h0001, {15'h0000, l4});
  endtask
  task automatic t_rereset();
    @(posedge clk);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    rd(8'h12, 8'hFF);
    chk("hb4_low_current_enable", 16'h0000, {15'h0000, l4});
  endtask
  task automatic finish_test();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Ceiling sits well above the roughly 120 cycles the scenarios need.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      finish_test();
    end
  end
  initial begin
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    t_reset();
    t_fields();
    t_steps();
    t_rereset();
    finish_test();
  end
endmodule
bind gdcr_regs gdcr_regs_props gdcr_regs_props_i (.clk(clk), .reset(reset), .address(address),
  .write_data(write_data), .write_strobe(write_strobe), .read_strobe(read_strobe), .read_data(read_data),
  .hb3_source_current_code(hb3_source_current_code), .hb3_sink_current_code(hb3_sink_current_code),
  .hb4_source_current_code(hb4_source_current_code), .hb4_sink_current_code(hb4_sink_current_code),
  .hb3_low_current_enable(hb3_low_current_enable), .hb4_low_current_enable(hb4_low_current_enable),
  .hb3_source_step(hb3_source_step), .hb4_sink_step(hb4_sink_step));
